// file: rtl/motor_ctrl_pkg.sv
// Constants, carriers and state types of the motor control register bank
// Summary of operation
// - Store trigger copies shadow configuration to memory
// - Load trigger reloads default configuration from memory
// - Write-one strobes clear faults and retry count
// - Nine-bit pinned angle held in bits 19:11
// - Applied angle is pinned angle modulo 360
// - Device clears tickle bit after seeing it
// - Device control register reads zero after reset
// - Speed source select picks digital speed field
package motor_ctrl_pkg;
   // Register offsets, as seen on the serial register port
   localparam logic [7:0] DEVICE_CONTROL_OFS = 8'hea;
   localparam logic [7:0] ALGORITHM_DEBUG_FIRST_OFS = 8'hec;
   localparam logic [7:0] ALGORITHM_DEBUG_SECOND_OFS = 8'hee;
   localparam logic [7:0] CURRENT_LOOP_GAINS_OFS = 8'hf0;
   localparam logic [7:0] SPEED_LOOP_GAINS_OFS = 8'hf2;
   localparam logic [7:0] ANALOG_OUT_FIRST_CONTROL_OFS = 8'hf4;
   localparam logic [7:0] ANALOG_OUT_SECOND_CONTROL_OFS = 8'hf6;
   // Reset values
   localparam logic [31:0] DEVICE_CONTROL_RST = 32'h00000000;
   localparam logic [31:0] ALGORITHM_DEBUG_RST = 32'h00000000;
   localparam logic [31:0] LOOP_GAINS_RST = 32'h00000000;
   localparam logic [31:0] ANALOG_OUT_FIRST_RST = 32'h00110000;
   localparam logic [31:0] ANALOG_OUT_SECOND_RST = 32'h00000000;
   localparam logic [31:0] UNMAPPED_READ = 32'h00000000;
   // Device control fields
   localparam int CONFIG_STORE_BIT = 31;
   localparam int CONFIG_LOAD_BIT = 30;
   localparam int FAULT_CLEAR_BIT = 29;
   localparam int RETRY_CLEAR_BIT = 28;
   localparam int ANGLE_MSB = 19;
   localparam int ANGLE_LSB = 11;
   localparam int TICKLE_BIT = 10;
   localparam int ANGLE_W = 9;
   localparam logic [8:0] FULL_TURN_DEG = 9'h168;
   localparam logic [8:0] ANGLE_RST = 9'h000;
   // Algorithm debug first fields
   localparam int SPEED_SOURCE_SELECT_BIT = 31;
   localparam int DIGITAL_SPEED_MSB = 30;
   localparam int DIGITAL_SPEED_LSB = 16;
   localparam int FORCE_ALIGN_EN_BIT = 14;
   localparam int SPEED_W = 15;
   localparam int ANALOG_SPEED_W = 12;
   // Keepalive timing: one unit of the interval, in ms, and its cycles
   localparam int CLK_HZ = 10_000_000;
   localparam int KEEPALIVE_UNIT_MS = 10;
   localparam int KEEPALIVE_UNIT_CYCLES = CLK_HZ / 1000 * KEEPALIVE_UNIT_MS;
   localparam int KEEPALIVE_CFG_W = 4;
   localparam int KEEPALIVE_CNT_W = 5;
   localparam int DIV_CNT_W = 20;

   // Request from the serial register port
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [31:0] wdata;
   } reg_req_t;

   // Answer to a read
   typedef struct packed {
      logic valid;
      logic [31:0] data;
   } reg_rsp_t;

   // Complete state of the register bank
   typedef struct packed {
      logic store;
      logic load;
      logic [8:0] angle;
      logic tickle;
      logic fault_clear;
      logic retry_clear;
      logic [31:0] debug_first;
      logic [31:0] debug_second;
      logic [31:0] current_gains;
      logic [31:0] speed_gains;
      logic [31:0] analog_first;
      logic [31:0] analog_second;
      logic [8:0] applied_angle;
      logic [14:0] speed_cmd;
      logic keepalive_fault;
      reg_rsp_t rsp;
   } bank_state_t;
endpackage : motor_ctrl_pkg

// file: rtl/tick_divider.sv
// Divider making a one-cycle enable pulse every DIV cycles
`timescale 1ns/1ps
`default_nettype none
module tick_divider
   import motor_ctrl_pkg::*;
#(
   parameter int DIV = KEEPALIVE_UNIT_CYCLES
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // Enable pulse
   output logic tick_o
);
   typedef struct packed {
      logic [DIV_CNT_W-1:0] cnt;
      logic tick;
   } div_state_t;

   localparam logic [DIV_CNT_W-1:0] LAST = DIV_CNT_W'(DIV - 1);

   div_state_t st_r;
   div_state_t st_nxt;

   // Count to the end of the unit and pulse
   always_comb begin
      st_nxt = st_r;
      st_nxt.tick = (st_r.cnt == LAST);
      if (st_r.cnt == LAST) begin
         st_nxt.cnt = '0;
      end else begin
         st_nxt.cnt = st_r.cnt + 1'b1;
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign tick_o = st_r.tick;
endmodule // tick_divider
`default_nettype wire

// file: rtl/keepalive_watch.sv
// Host keepalive watchdog counting interval units between tickles
`timescale 1ns/1ps
`default_nettype none
module keepalive_watch
   import motor_ctrl_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // Control
   input wire logic unit_tick_i,
   input wire logic arm_i,
   input wire logic tickle_i,
   input wire logic [KEEPALIVE_CFG_W-1:0] interval_i,
   // Expiry pulse
   output logic expired_o
);
   typedef struct packed {
      logic [KEEPALIVE_CNT_W-1:0] units;
      logic expired;
   } watch_state_t;

   watch_state_t st_r;
   watch_state_t st_nxt;
   logic [KEEPALIVE_CNT_W-1:0] limit;

   // Interval is the configured value plus one units
   assign limit = KEEPALIVE_CNT_W'(interval_i) + 1'b1;

   // Restart on tickle or while disarmed, expire at the limit
   always_comb begin
      st_nxt = st_r;
      st_nxt.expired = 1'b0;
      if (!arm_i || tickle_i) begin
         st_nxt.units = '0;
      end else if (unit_tick_i) begin
         if (st_r.units + 1'b1 >= limit) begin
            st_nxt.expired = 1'b1;
            st_nxt.units = '0;
         end else begin
            st_nxt.units = st_r.units + 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign expired_o = st_r.expired;
endmodule // keepalive_watch
`default_nettype wire

// file: rtl/motor_ctrl_regs.sv
// Device control and algorithm control register bank
`timescale 1ns/1ps
`default_nettype none
module motor_ctrl_regs
   import motor_ctrl_pkg::*;
#(
   parameter int UNIT_CYCLES = KEEPALIVE_UNIT_CYCLES
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // Serial register port
   input wire reg_req_t req_i,
   output reg_rsp_t rsp_o,
   // Configuration memory transfer
   output logic config_store_trigger_o,
   output logic config_load_trigger_o,
   input wire logic nv_done_i,
   // Fault handling
   output logic fault_clear_strobe_o,
   output logic retry_counter_clear_strobe_o,
   output logic keepalive_fault_o,
   // Keepalive configuration
   input wire logic serial_speed_mode_i,
   input wire logic [KEEPALIVE_CFG_W-1:0] host_keepalive_interval_i,
   // Alignment
   output logic force_align_en_o,
   output logic [ANGLE_W-1:0] applied_angle_o,
   // Speed command
   input wire logic [ANALOG_SPEED_W-1:0] analog_speed_i,
   output logic speed_source_select_o,
   output logic [SPEED_W-1:0] speed_cmd_o,
   // Raw control words for the algorithm
   output logic [31:0] debug_second_o,
   output logic [31:0] current_gains_o,
   output logic [31:0] speed_gains_o,
   output logic [31:0] analog_first_o,
   output logic [31:0] analog_second_o
);
   bank_state_t st_r;
   bank_state_t st_nxt;
   logic unit_tick;
   logic expired;
   logic wr_ctl;
   logic [ANGLE_W-1:0] new_angle;
   logic [31:0] new_debug;

   // Unit pulse for the keepalive interval
   tick_divider #(
      .DIV(UNIT_CYCLES)
   ) u_div (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .tick_o(unit_tick)
   );

   // Watchdog on host tickles, armed in serial speed mode
   keepalive_watch u_watch (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .unit_tick_i(unit_tick),
      .arm_i(serial_speed_mode_i),
      .tickle_i(st_r.tickle),
      .interval_i(host_keepalive_interval_i),
      .expired_o(expired)
   );

   assign wr_ctl = req_i.wr && (req_i.addr == DEVICE_CONTROL_OFS);

   // Next register state
   always_comb begin
      st_nxt = st_r;
      st_nxt.fault_clear = 1'b0;
      st_nxt.retry_clear = 1'b0;
      st_nxt.rsp.valid = 1'b0;
      new_angle = st_r.angle;
      new_debug = st_r.debug_first;

      // Completion of a transfer drops its trigger; store is served first
      if (nv_done_i && st_r.store) begin
         st_nxt.store = 1'b0;
      end else if (nv_done_i && st_r.load) begin
         st_nxt.load = 1'b0;
      end
      // Tickle is consumed by the watchdog one cycle after it is written
      if (st_r.tickle) begin
         st_nxt.tickle = 1'b0;
      end

      // Register writes; a new trigger wins over a completion
      if (req_i.wr) begin
         case (req_i.addr)
            DEVICE_CONTROL_OFS: begin
               if (req_i.wdata[CONFIG_STORE_BIT]) begin
                  st_nxt.store = 1'b1;
               end
               if (req_i.wdata[CONFIG_LOAD_BIT]) begin
                  st_nxt.load = 1'b1;
               end
               st_nxt.fault_clear = req_i.wdata[FAULT_CLEAR_BIT];
               st_nxt.retry_clear = req_i.wdata[RETRY_CLEAR_BIT];
               new_angle = req_i.wdata[ANGLE_MSB:ANGLE_LSB];
               st_nxt.tickle = req_i.wdata[TICKLE_BIT];
            end
            ALGORITHM_DEBUG_FIRST_OFS: begin
               new_debug = req_i.wdata;
            end
            ALGORITHM_DEBUG_SECOND_OFS: begin
               st_nxt.debug_second = req_i.wdata;
            end
            CURRENT_LOOP_GAINS_OFS: begin
               st_nxt.current_gains = req_i.wdata;
            end
            SPEED_LOOP_GAINS_OFS: begin
               st_nxt.speed_gains = req_i.wdata;
            end
            ANALOG_OUT_FIRST_CONTROL_OFS: begin
               st_nxt.analog_first = req_i.wdata;
            end
            ANALOG_OUT_SECOND_CONTROL_OFS: begin
               st_nxt.analog_second = req_i.wdata;
            end
            default: begin
               // Reserved offsets ignore writes
            end
         endcase
      end
      st_nxt.angle = new_angle;
      st_nxt.debug_first = new_debug;

      // Applied angle folds the pinned value into one turn
      if (new_angle >= FULL_TURN_DEG) begin
         st_nxt.applied_angle = new_angle - FULL_TURN_DEG;
      end else begin
         st_nxt.applied_angle = new_angle;
      end

      // Speed command source
      if (new_debug[SPEED_SOURCE_SELECT_BIT]) begin
         st_nxt.speed_cmd = new_debug[DIGITAL_SPEED_MSB:DIGITAL_SPEED_LSB];
      end else begin
         st_nxt.speed_cmd = SPEED_W'(analog_speed_i);
      end

      // Keepalive fault: expiry wins over a fault clear in the same cycle
      if (expired) begin
         st_nxt.keepalive_fault = 1'b1;
      end else if (wr_ctl && req_i.wdata[FAULT_CLEAR_BIT]) begin
         st_nxt.keepalive_fault = 1'b0;
      end

      // Register reads; write-only fields and reserved offsets read zero
      if (req_i.rd) begin
         st_nxt.rsp.valid = 1'b1;
         case (req_i.addr)
            DEVICE_CONTROL_OFS: begin
               st_nxt.rsp.data = UNMAPPED_READ;
               st_nxt.rsp.data[CONFIG_STORE_BIT] = st_r.store;
               st_nxt.rsp.data[CONFIG_LOAD_BIT] = st_r.load;
               st_nxt.rsp.data[TICKLE_BIT] = st_r.tickle;
            end
            CURRENT_LOOP_GAINS_OFS: begin
               st_nxt.rsp.data = st_r.current_gains;
            end
            SPEED_LOOP_GAINS_OFS: begin
               st_nxt.rsp.data = st_r.speed_gains;
            end
            ANALOG_OUT_FIRST_CONTROL_OFS: begin
               st_nxt.rsp.data = st_r.analog_first;
            end
            ANALOG_OUT_SECOND_CONTROL_OFS: begin
               st_nxt.rsp.data = st_r.analog_second;
            end
            default: begin
               st_nxt.rsp.data = UNMAPPED_READ;
            end
         endcase
      end
   end

   // State register with documented reset values
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         st_r <= '0;
         st_r.store <= DEVICE_CONTROL_RST[CONFIG_STORE_BIT];
         st_r.load <= DEVICE_CONTROL_RST[CONFIG_LOAD_BIT];
         st_r.angle <= ANGLE_RST;
         st_r.tickle <= DEVICE_CONTROL_RST[TICKLE_BIT];
         st_r.debug_first <= ALGORITHM_DEBUG_RST;
         st_r.debug_second <= ALGORITHM_DEBUG_RST;
         st_r.current_gains <= LOOP_GAINS_RST;
         st_r.speed_gains <= LOOP_GAINS_RST;
         st_r.analog_first <= ANALOG_OUT_FIRST_RST;
         st_r.analog_second <= ANALOG_OUT_SECOND_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs straight from the state register
   assign rsp_o = st_r.rsp;
   assign config_store_trigger_o = st_r.store;
   assign config_load_trigger_o = st_r.load;
   assign fault_clear_strobe_o = st_r.fault_clear;
   assign retry_counter_clear_strobe_o = st_r.retry_clear;
   assign keepalive_fault_o = st_r.keepalive_fault;
   assign force_align_en_o = st_r.debug_first[FORCE_ALIGN_EN_BIT];
   assign applied_angle_o = st_r.applied_angle;
   assign speed_source_select_o = st_r.debug_first[SPEED_SOURCE_SELECT_BIT];
   assign speed_cmd_o = st_r.speed_cmd;
   assign debug_second_o = st_r.debug_second;
   assign current_gains_o = st_r.current_gains;
   assign speed_gains_o = st_r.speed_gains;
   assign analog_first_o = st_r.analog_first;
   assign analog_second_o = st_r.analog_second;
endmodule // motor_ctrl_regs
`default_nettype wire

// file: test/motor_ctrl_checker.sv
// Concurrent checks on the motor control register bank ports
`timescale 1ns/1ps
`default_nettype none
module motor_ctrl_checker
   import motor_ctrl_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // Register port
   input wire reg_req_t req_i,
   input wire reg_rsp_t rsp_o,
   // Watched outputs and the completion input
   input wire logic config_store_trigger_o,
   input wire logic config_load_trigger_o,
   input wire logic nv_done_i,
   input wire logic fault_clear_strobe_o,
   input wire logic retry_counter_clear_strobe_o,
   input wire logic [ANGLE_W-1:0] applied_angle_o,
   input wire logic force_align_en_o,
   input wire logic speed_source_select_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (reset_i);
   logic wr_ea;
   logic str_wr;
   logic flt_wr;
   logic rty_wr;
   logic tkl_wr;
   logic ctl_rd;
   logic dbg_wr;
   logic [8:0] ang_exp;
   // Writes and reads of the control word, the angle a control write should yield, and writes of the debug word
   assign wr_ea = req_i.wr && req_i.addr == DEVICE_CONTROL_OFS;
   assign str_wr = wr_ea && req_i.wdata[31];
   assign flt_wr = wr_ea && req_i.wdata[29];
   assign rty_wr = wr_ea && req_i.wdata[28];
   assign tkl_wr = wr_ea && req_i.wdata[10];
   assign ctl_rd = req_i.rd && req_i.addr == DEVICE_CONTROL_OFS;
   assign dbg_wr = req_i.wr && req_i.addr == ALGORITHM_DEBUG_FIRST_OFS;
   assign ang_exp = req_i.wdata[19:11] >= FULL_TURN_DEG ?
      req_i.wdata[19:11] - FULL_TURN_DEG : req_i.wdata[19:11];

   chk_store_set: assert property (str_wr |=> config_store_trigger_o)
      else $error("store trigger not raised");
   chk_load_set: assert property (wr_ea && req_i.wdata[30] |=> config_load_trigger_o)
      else $error("load trigger not raised");
   chk_fault_pulse: assert property (fault_clear_strobe_o |-> $past(flt_wr))
      else $error("fault clear without its write");
   chk_retry_pulse: assert property (rty_wr ##1 !rty_wr |-> retry_counter_clear_strobe_o
      ##1 !retry_counter_clear_strobe_o)
      else $error("retry clear not a single pulse");
   chk_angle_mod: assert property (wr_ea |=> applied_angle_o == $past(ang_exp))
      else $error("applied angle wrong");
   chk_ctrl_readback: assert property (rsp_o.valid && $past(ctl_rd) |->
      (rsp_o.data & 32'h3fff_fbff) == '0)
      else $error("write-only control bits read back");
   chk_tickle_self: assert property (ctl_rd && !req_i.wr && !$past(tkl_wr) |=>
      !rsp_o.data[10])
      else $error("tickle bit not cleared");
   chk_trigger_done: assert property (config_store_trigger_o && nv_done_i && !str_wr |=>
      !config_store_trigger_o)
      else $error("store trigger kept after done");
   chk_speed_sel: assert property (dbg_wr |=>
      speed_source_select_o == $past(req_i.wdata[31]) &&
      force_align_en_o == $past(req_i.wdata[14]))
      else $error("debug control bits wrong");
endmodule // motor_ctrl_checker

bind motor_ctrl_regs motor_ctrl_checker motor_ctrl_checker_i (.clk_i, .reset_i, .req_i, .rsp_o,
   .config_store_trigger_o, .config_load_trigger_o, .nv_done_i, .fault_clear_strobe_o,
   .retry_counter_clear_strobe_o, .applied_angle_o, .force_align_en_o, .speed_source_select_o);
`default_nettype wire

// file: test/nv_mem_model.sv
// Model of the configuration memory answering store and load requests
`timescale 1ns/1ps
`default_nettype none
module nv_mem_model #(
   parameter int LAT = 5
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // Transfer requests and completion
   input wire logic store_i,
   input wire logic load_i,
   output logic done_o
);
   int cnt;
   // One completion pulse per pending transfer, LAT+2 cycles apart
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         cnt <= 0;
         done_o <= 1'b0;
      end else begin
         done_o <= 1'b0;
         if ((store_i || load_i) && !done_o) begin
            cnt <= cnt + 1;
            if (cnt == LAT) begin
               cnt <= 0;
               done_o <= 1'b1;
            end
         end
      end
   end
endmodule // nv_mem_model
`default_nettype wire

// file: test/testbench.sv
// Self-checking bench for the motor control register bank
`timescale 1ns/1ps
`default_nettype none
module testbench
   import motor_ctrl_pkg::*;
;
   logic clk_i = 1'b0;
   logic reset_i = 1'b1;
   reg_req_t req_i = '0;
   reg_rsp_t rsp_o;
   logic store_o, load_o, nv_done_i, flt_o, rty_o, kaf_o, sel_o, fa_o;
   logic mode_i = 1'b0;
   logic [3:0] ival_i = 4'h2;
   logic [11:0] an_i = 12'habc;
   logic [8:0] ang_o;
   logic [14:0] spd_o;
   logic [31:0] dbg2_o, cur_o, spg_o, af_o, as_o;
   logic [8:0] ang_exp;
   int mismatches = 0;
   int samples_checked = 0;
   int i;
   logic [8:0] ang_tab [4] = '{9'h000, 9'h167, 9'h168, 9'h1ff};
   logic [7:0] rw_tab [4] = '{CURRENT_LOOP_GAINS_OFS, SPEED_LOOP_GAINS_OFS,
      ANALOG_OUT_FIRST_CONTROL_OFS, ANALOG_OUT_SECOND_CONTROL_OFS};
   logic [31:0] rst_tab [4] = '{LOOP_GAINS_RST, LOOP_GAINS_RST, ANALOG_OUT_FIRST_RST,
      ANALOG_OUT_SECOND_RST};

   // Clock of 100 ns period
   initial begin
      forever #50 clk_i = ~clk_i;
   end

   motor_ctrl_regs #(.UNIT_CYCLES(4)) motor_ctrl_regs_i (.clk_i(clk_i), .reset_i(reset_i),
      .req_i(req_i), .rsp_o(rsp_o), .config_store_trigger_o(store_o),
      .config_load_trigger_o(load_o), .nv_done_i(nv_done_i), .fault_clear_strobe_o(flt_o),
      .retry_counter_clear_strobe_o(rty_o), .keepalive_fault_o(kaf_o),
      .serial_speed_mode_i(mode_i), .host_keepalive_interval_i(ival_i),
      .force_align_en_o(fa_o), .applied_angle_o(ang_o), .analog_speed_i(an_i),
      .speed_source_select_o(sel_o), .speed_cmd_o(spd_o), .debug_second_o(dbg2_o),
      .current_gains_o(cur_o), .speed_gains_o(spg_o), .analog_first_o(af_o),
      .analog_second_o(as_o));

   nv_mem_model nv_mem_model_i (.clk_i(clk_i), .reset_i(reset_i), .store_i(store_o),
      .load_i(load_o), .done_o(nv_done_i));

   // Compare and count
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         mismatches++;
         $display("FAIL %s expected %h seen %h", n, e, g);
      end
   endtask

   // Word write, entered and left at a falling edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      req_i.wr = 1'b1;
      req_i.addr = a;
      req_i.wdata = d;
      @(negedge clk_i);
      req_i.wr = 1'b0;
   endtask

   // Word read; the answer stands in the cycle after the request
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
      req_i.rd = 1'b1;
      req_i.addr = a;
      @(negedge clk_i);
      req_i.rd = 1'b0;
      chk({n, "_valid"}, 32'h1, {31'h0, rsp_o.valid});
      chk(n, e, rsp_o.data);
      // Idle cycle so a following request never re-raises its strobe at once
      @(negedge clk_i);
   endtask

   // Bounded wait for a level
   task automatic wait_lvl(ref logic s, input logic v, input string n);
      for (int k = 0; k < 200 && s !== v; k++) @(negedge clk_i);
      if (s !== v) begin
         mismatches++;
         $display("FAIL %s expected %b seen %b", n, v, s);
         end_of_test();
      end
   endtask

   task automatic done_t(input string n);
      $display("test %s done", n);
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      repeat (3) @(posedge clk_i);
      @(negedge clk_i);
      reset_i = 1'b0;
      rd(DEVICE_CONTROL_OFS, DEVICE_CONTROL_RST, "ctrl_rst");
      for (i = 0; i < 4; i++) rd(rw_tab[i], rst_tab[i], "rst");
      chk("af_rst", ANALOG_OUT_FIRST_RST, af_o);
      done_t("reset");
      for (i = 0; i < 4; i++) begin
         wr(rw_tab[i], 32'h5a00_0000 | 32'(i));
         rd(rw_tab[i], 32'h5a00_0000 | 32'(i), "rw");
      end
      chk("cur", 32'h5a00_0000, cur_o);
      chk("spg", 32'h5a00_0001, spg_o);
      chk("af", 32'h5a00_0002, af_o);
      chk("as", 32'h5a00_0003, as_o);
      wr(8'he0, 32'hffff_ffff);
      rd(8'he0, UNMAPPED_READ, "unmapped");
      wr(ALGORITHM_DEBUG_SECOND_OFS, 32'h1234_5678);
      chk("dbg2", 32'h1234_5678, dbg2_o);
      rd(ALGORITHM_DEBUG_SECOND_OFS, 32'h0, "dbg2_wo");
      done_t("regs");
      wr(DEVICE_CONTROL_OFS, 32'hc000_0000);
      chk("store", 32'h1, {31'h0, store_o});
      chk("load", 32'h1, {31'h0, load_o});
      wait_lvl(store_o, 1'b0, "store_done");
      chk("load_pend", 32'h1, {31'h0, load_o});
      wait_lvl(load_o, 1'b0, "load_done");
      rd(DEVICE_CONTROL_OFS, 32'h0, "ctrl_idle");
      wr(DEVICE_CONTROL_OFS, 32'h3000_0000);
      chk("flt", 32'h1, {31'h0, flt_o});
      chk("rty", 32'h1, {31'h0, rty_o});
      @(negedge clk_i);
      chk("flt_end", 32'h0, {31'h0, flt_o});
      chk("rty_end", 32'h0, {31'h0, rty_o});
      done_t("strobes");
      for (i = 0; i < 4; i++) begin
         wr(DEVICE_CONTROL_OFS, 32'(ang_tab[i]) << 11);
         ang_exp = ang_tab[i] >= FULL_TURN_DEG ? ang_tab[i] - FULL_TURN_DEG : ang_tab[i];
         chk("angle", 32'(ang_exp), 32'(ang_o));
         @(negedge clk_i);
      end
      rd(DEVICE_CONTROL_OFS, 32'h0, "angle_wo");
      wr(DEVICE_CONTROL_OFS, 32'h0000_0400);
      rd(DEVICE_CONTROL_OFS, 32'h0000_0400, "tickle_set");
      rd(DEVICE_CONTROL_OFS, 32'h0, "tickle_clr");
      done_t("angle_tickle");
      wr(ALGORITHM_DEBUG_FIRST_OFS, 32'h9234_4000);
      @(negedge clk_i);
      chk("sel", 32'h1, {31'h0, sel_o});
      chk("align", 32'h1, {31'h0, fa_o});
      chk("spd_dig", 32'h1234, 32'(spd_o));
      rd(ALGORITHM_DEBUG_FIRST_OFS, 32'h0, "dbg1_wo");
      wr(ALGORITHM_DEBUG_FIRST_OFS, 32'h0);
      @(negedge clk_i);
      chk("spd_an", 32'h0abc, 32'(spd_o));
      done_t("speed");
      mode_i = 1'b1;
      repeat (12) begin
         wr(DEVICE_CONTROL_OFS, 32'h0000_0400);
         @(negedge clk_i);
      end
      chk("kaf_fed", 32'h0, {31'h0, kaf_o});
      wait_lvl(kaf_o, 1'b1, "kaf_set");
      mode_i = 1'b0;
      wr(DEVICE_CONTROL_OFS, 32'h2000_0000);
      chk("kaf_clr", 32'h0, {31'h0, kaf_o});
      done_t("watchdog");
      // Reset in mid-run with a trigger, angle and tickle pending
      wr(DEVICE_CONTROL_OFS, 32'h80ff_8400);
      reset_i = 1'b1;
      @(negedge clk_i);
      reset_i = 1'b0;
      chk("store_rst", 32'h0, {31'h0, store_o});
      chk("angle_rst", 32'h0, 32'(ang_o));
      rd(DEVICE_CONTROL_OFS, DEVICE_CONTROL_RST, "ctrl_rst2");
      done_t("mid_reset");
      end_of_test();
   end
endmodule // testbench
`default_nettype wire
